// *** common/dct_pkg.sv ***
// Purpose: Constants shared by the DRAM command-spacing tracker.
// Assumes: One channel of four ranks with eight banks each; byte-wide register port.
// Notes:   Register image starts at the activate timing register's first byte.
//
// How it works
// R1: Count activates per rank in window; block excess.
// R2: Control bit set to one applies four-activate limit.
// R3: Space activates to one rank by gap.
// R4: Precharge to activate, same rank and bank.
// R5: Precharge-all to activate, same rank.
// R6: Refresh to activate, same rank.
// R7: Activate to write, same rank and bank.
// R8: Write to write, same rank.
// R9: Write to write, different ranks.
// R10: Read to write, any rank.
// R11: Activate to read, same rank and bank.
// R12: Write to read, same rank.
// R13: Write to read, different ranks.
// R14: Read to read, same rank.
// R15: Read to read, different ranks.
// R16: Gap counts from issue edge; zero means none.

package dct_pkg;

  localparam int RANKS     = 4;
  localparam int BANKS     = 8;
  localparam int RANK_W    = 2;
  localparam int BANK_W    = 3;
  localparam int ACT_LIMIT = 4;

  // ************************************************************
  // Register map, byte addresses
  // ************************************************************
  localparam logic [11:0] ACTIVATE_TIMING_OFS = 12'h652;
  localparam logic [11:0] WRITE_TIMING_OFS    = 12'h656;
  localparam logic [11:0] READ_TIMING_OFS     = 12'h658;
  localparam int          CFG_BYTES           = 9;
  localparam logic [31:0] ACTIVATE_TIMING_RST = 32'h00000000;
  localparam logic [15:0] WRITE_TIMING_RST    = 16'h0000;
  localparam logic [23:0] READ_TIMING_RST     = 24'h000000;
  // Writable bits of each byte; reserved bits read as zero.
  localparam logic [8*CFG_BYTES-1:0] CFG_WMASK = 72'h1f_ffff_ffff_0fff_ffff;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int WINDOW_LEN_LSB   = 22;
  localparam int WINDOW_LEN_W     = 6;
  localparam int LIMIT_CTRL_BIT   = 21;
  localparam int ACT_ACT_LSB      = 17;
  localparam int PRE_ACT_LSB      = 13;
  localparam int PREALL_ACT_LSB   = 9;
  localparam int REF_ACT_LSB      = 0;
  localparam int REF_ACT_W        = 9;
  localparam int ACT_WR_LSB       = 12;
  localparam int WR_WR_SAME_LSB   = 8;
  localparam int WR_WR_OTHER_LSB  = 4;
  localparam int RD_WR_LSB        = 0;
  localparam int ACT_RD_LSB       = 17;
  localparam int WR_RD_SAME_LSB   = 12;
  localparam int WR_RD_SAME_W     = 5;
  localparam int WR_RD_OTHER_LSB  = 8;
  localparam int RD_RD_SAME_LSB   = 4;
  localparam int RD_RD_OTHER_LSB  = 0;
  localparam int GAP_W            = 4;

  // ************************************************************
  // Command codes
  // ************************************************************
  typedef enum logic [2:0] {
    CMD_ACT    = 3'h0,
    CMD_PRE    = 3'h1,
    CMD_PREALL = 3'h2,
    CMD_REF    = 3'h3,
    CMD_RD     = 3'h4,
    CMD_WR     = 3'h5
  } dct_cmd_t;

endpackage : dct_pkg

// *** logic/dct_gap_timer.sv ***
// Purpose: One spacing counter between an earlier and a later command.
// Assumes: start marks the clock edge at which the earlier command issues.
// Notes:   ready is high from the cycle gap cycles after the issue cycle.
`timescale 1ns/10ps
`default_nettype none

module dct_gap_timer #(
  parameter int W = 4
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [W-1:0] gap,
  output var  logic         ready
);

  logic [W-1:0] remain;

  // Loading gap minus one makes a gap of one and of zero both free next cycle.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      remain <= '0;
    end else if (start) begin
      remain <= (gap == '0) ? '0 : W'(gap - W'(1)); // [R16]
    end else if (remain != '0) begin
      remain <= W'(remain - W'(1));
    end
  end

  assign ready = (remain == '0);

endmodule : dct_gap_timer

`default_nettype wire

// *** logic/dct_spacing_tracker.sv ***
// Purpose: Gate command launch from the scheduler by programmed command spacings.
// Assumes: Scheduler holds a request until launchValid shows it, then moves on.
// Notes:   Precharge, precharge-all and refresh are held off only in the cycle after a launch.
`timescale 1ns/10ps
`default_nettype none

module dct_spacing_tracker (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic [11:0]                cfgAddr,
  input  wire logic                       cfgWrEn,
  input  wire logic                       cfgRdEn,
  input  wire logic [7:0]                 cfgWrData,
  output var  logic [7:0]                 cfgRdData,
  input  wire logic                       reqValid,
  input  wire logic [2:0]                 reqCmd,
  input  wire logic [dct_pkg::RANK_W-1:0] reqRank,
  input  wire logic [dct_pkg::BANK_W-1:0] reqBank,
  output var  logic                       launchValid,
  output var  logic [2:0]                 launchCmd,
  output var  logic [dct_pkg::RANK_W-1:0] launchRank,
  output var  logic [dct_pkg::BANK_W-1:0] launchBank,
  output var  logic [dct_pkg::RANKS-1:0]  windowFull
);

  localparam int RB = dct_pkg::RANKS * dct_pkg::BANKS;

  // ************************************************************
  // Register image
  // ************************************************************
  logic [7:0]  cfgByte [dct_pkg::CFG_BYTES];
  logic [11:0] cfgIdx;
  logic        cfgHit;
  logic [31:0] actTiming;
  logic [15:0] wrTiming;
  logic [23:0] rdTiming;

  assign cfgIdx = 12'(cfgAddr - dct_pkg::ACTIVATE_TIMING_OFS);
  assign cfgHit = (cfgAddr >= dct_pkg::ACTIVATE_TIMING_OFS)
               && (cfgIdx < 12'(dct_pkg::CFG_BYTES));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < dct_pkg::CFG_BYTES; i++) begin
        cfgByte[i] <= 8'h00;
      end
    end else if (cfgWrEn && cfgHit) begin
      cfgByte[cfgIdx[3:0]] <= cfgWrData & dct_pkg::CFG_WMASK[cfgIdx[3:0]*8 +: 8];
    end
  end

  // Unmapped addresses read as zero rather than holding the last value.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfgRdData <= 8'h00;
    end else if (cfgRdEn) begin
      cfgRdData <= cfgHit ? cfgByte[cfgIdx[3:0]] : 8'h00;
    end
  end

  assign actTiming = {cfgByte[3], cfgByte[2], cfgByte[1], cfgByte[0]};
  assign wrTiming  = {cfgByte[5], cfgByte[4]};
  assign rdTiming  = {cfgByte[8], cfgByte[7], cfgByte[6]};

  logic [dct_pkg::WINDOW_LEN_W-1:0] windowLen;
  logic                             limitOn;
  logic [dct_pkg::GAP_W-1:0]        gActAct;
  logic [dct_pkg::GAP_W-1:0]        gPreAct;
  logic [dct_pkg::GAP_W-1:0]        gPreallAct;
  logic [dct_pkg::REF_ACT_W-1:0]    gRefAct;
  logic [dct_pkg::GAP_W-1:0]        gActWr;
  logic [dct_pkg::GAP_W-1:0]        gWrWrSame;
  logic [dct_pkg::GAP_W-1:0]        gWrWrOther;
  logic [dct_pkg::GAP_W-1:0]        gRdWr;
  logic [dct_pkg::GAP_W-1:0]        gActRd;
  logic [dct_pkg::WR_RD_SAME_W-1:0] gWrRdSame;
  logic [dct_pkg::GAP_W-1:0]        gWrRdOther;
  logic [dct_pkg::GAP_W-1:0]        gRdRdSame;
  logic [dct_pkg::GAP_W-1:0]        gRdRdOther;

  assign windowLen  = actTiming[dct_pkg::WINDOW_LEN_LSB +: dct_pkg::WINDOW_LEN_W];
  assign limitOn    = actTiming[dct_pkg::LIMIT_CTRL_BIT]; // [R2]
  assign gActAct    = actTiming[dct_pkg::ACT_ACT_LSB +: dct_pkg::GAP_W];
  assign gPreAct    = actTiming[dct_pkg::PRE_ACT_LSB +: dct_pkg::GAP_W];
  assign gPreallAct = actTiming[dct_pkg::PREALL_ACT_LSB +: dct_pkg::GAP_W];
  assign gRefAct    = actTiming[dct_pkg::REF_ACT_LSB +: dct_pkg::REF_ACT_W];
  assign gActWr     = wrTiming[dct_pkg::ACT_WR_LSB +: dct_pkg::GAP_W];
  assign gWrWrSame  = wrTiming[dct_pkg::WR_WR_SAME_LSB +: dct_pkg::GAP_W];
  assign gWrWrOther = wrTiming[dct_pkg::WR_WR_OTHER_LSB +: dct_pkg::GAP_W];
  assign gRdWr      = wrTiming[dct_pkg::RD_WR_LSB +: dct_pkg::GAP_W];
  assign gActRd     = rdTiming[dct_pkg::ACT_RD_LSB +: dct_pkg::GAP_W];
  assign gWrRdSame  = rdTiming[dct_pkg::WR_RD_SAME_LSB +: dct_pkg::WR_RD_SAME_W];
  assign gWrRdOther = rdTiming[dct_pkg::WR_RD_OTHER_LSB +: dct_pkg::GAP_W];
  assign gRdRdSame  = rdTiming[dct_pkg::RD_RD_SAME_LSB +: dct_pkg::GAP_W];
  assign gRdRdOther = rdTiming[dct_pkg::RD_RD_OTHER_LSB +: dct_pkg::GAP_W];

  // ************************************************************
  // Launch decision
  // ************************************************************
  logic                       take;
  logic                       allow;
  logic                       isAct;
  logic                       isRd;
  logic                       isWr;
  logic [RB-1:0]              rbSel;
  logic [dct_pkg::RANKS-1:0]  rkSel;
  logic [4:0]                 reqRb;
  logic [dct_pkg::RANK_W-1:0] lastWrRank;
  logic [dct_pkg::RANK_W-1:0] lastRdRank;
  logic                       anyWr;
  logic                       anyRd;

  logic [dct_pkg::RANKS-1:0]  rdyActAct;
  logic [dct_pkg::RANKS-1:0]  rdyPreallAct;
  logic [dct_pkg::RANKS-1:0]  rdyRefAct;
  logic [dct_pkg::RANKS-1:0]  rdyWrWrSame;
  logic [dct_pkg::RANKS-1:0]  rdyWrRdSame;
  logic [dct_pkg::RANKS-1:0]  rdyRdRdSame;
  logic [RB-1:0]              rdyPreAct;
  logic [RB-1:0]              rdyActWr;
  logic [RB-1:0]              rdyActRd;
  logic                       rdyWrWrOther;
  logic                       rdyRdWr;
  logic                       rdyWrRdOther;
  logic                       rdyRdRdOther;
  logic [2:0]                 actCount [dct_pkg::RANKS];
  logic [dct_pkg::WINDOW_LEN_W-1:0] winLeft [dct_pkg::RANKS];
  logic                       actRoom;
  logic                       actOk;
  logic                       wrOk;
  logic                       rdOk;

  assign reqRb = {reqRank, reqBank};
  assign isAct = (reqCmd == 3'(dct_pkg::CMD_ACT));
  assign isRd  = (reqCmd == 3'(dct_pkg::CMD_RD));
  assign isWr  = (reqCmd == 3'(dct_pkg::CMD_WR));

  assign actRoom = !limitOn || (actCount[reqRank] < 3'(dct_pkg::ACT_LIMIT)); // [R1] [R2]
  assign actOk   = rdyActAct[reqRank]                                      // [R3]
                && rdyPreAct[reqRb]                                         // [R4]
                && rdyPreallAct[reqRank]                                    // [R5]
                && rdyRefAct[reqRank]                                       // [R6]
                && actRoom;
  assign wrOk    = rdyActWr[reqRb]                                          // [R7]
                && rdyWrWrSame[reqRank]                                     // [R8]
                && (!anyWr || lastWrRank == reqRank || rdyWrWrOther)        // [R9]
                && rdyRdWr;                                                 // [R10]
  assign rdOk    = rdyActRd[reqRb]                                          // [R11]
                && rdyWrRdSame[reqRank]                                     // [R12]
                && (!anyWr || lastWrRank == reqRank || rdyWrRdOther)        // [R13]
                && rdyRdRdSame[reqRank]                                     // [R14]
                && (!anyRd || lastRdRank == reqRank || rdyRdRdOther);       // [R15]

  assign allow = isAct ? actOk : (isWr ? wrOk : (isRd ? rdOk : 1'b1));
  // The cycle after a launch is skipped so a held request is never issued twice.
  assign take  = reqValid && !launchValid && allow;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      launchValid <= 1'b0;
      launchCmd   <= 3'h0;
      launchRank  <= '0;
      launchBank  <= '0;
    end else begin
      launchValid <= take;
      if (take) begin
        launchCmd  <= reqCmd;
        launchRank <= reqRank;
        launchBank <= reqBank;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lastWrRank <= '0;
      lastRdRank <= '0;
      anyWr      <= 1'b0;
      anyRd      <= 1'b0;
    end else if (take && isWr) begin
      lastWrRank <= reqRank;
      anyWr      <= 1'b1;
    end else if (take && isRd) begin
      lastRdRank <= reqRank;
      anyRd      <= 1'b1;
    end
  end

  // ************************************************************
  // Spacing timers
  // ************************************************************
  always_comb begin
    rbSel = '0;
    rkSel = '0;
    rbSel[reqRb]   = take;
    rkSel[reqRank] = take;
  end

  for (genvar r = 0; r < dct_pkg::RANKS; r++) begin : g_rank
    dct_gap_timer #(.W(dct_pkg::GAP_W)) u_actAct (
      .core_clk(core_clk), .rst(rst), .start(rkSel[r] && isAct),
      .gap(gActAct), .ready(rdyActAct[r]));                                  // [R3]
    dct_gap_timer #(.W(dct_pkg::GAP_W)) u_preallAct (
      .core_clk(core_clk), .rst(rst),
      .start(rkSel[r] && reqCmd == 3'(dct_pkg::CMD_PREALL)),
      .gap(gPreallAct), .ready(rdyPreallAct[r]));                            // [R5]
    dct_gap_timer #(.W(dct_pkg::REF_ACT_W)) u_refAct (
      .core_clk(core_clk), .rst(rst),
      .start(rkSel[r] && reqCmd == 3'(dct_pkg::CMD_REF)),
      .gap(gRefAct), .ready(rdyRefAct[r]));                                  // [R6]
    dct_gap_timer #(.W(dct_pkg::GAP_W)) u_wrWrSame (
      .core_clk(core_clk), .rst(rst), .start(rkSel[r] && isWr),
      .gap(gWrWrSame), .ready(rdyWrWrSame[r]));                              // [R8]
    dct_gap_timer #(.W(dct_pkg::WR_RD_SAME_W)) u_wrRdSame (
      .core_clk(core_clk), .rst(rst), .start(rkSel[r] && isWr),
      .gap(gWrRdSame), .ready(rdyWrRdSame[r]));                              // [R12]
    dct_gap_timer #(.W(dct_pkg::GAP_W)) u_rdRdSame (
      .core_clk(core_clk), .rst(rst), .start(rkSel[r] && isRd),
      .gap(gRdRdSame), .ready(rdyRdRdSame[r]));                              // [R14]

    // A window opens at the first activate and closes on its own count.
    always_ff @(posedge core_clk) begin
      if (rst) begin
        winLeft[r]  <= '0;
        actCount[r] <= 3'h0;
      end else if (winLeft[r] <= 6'h01) begin
        winLeft[r]  <= (rkSel[r] && isAct) ? windowLen : 6'h00;                // [R1]
        actCount[r] <= (rkSel[r] && isAct && windowLen != 6'h00) ? 3'h1 : 3'h0;
      end else begin
        winLeft[r] <= 6'(winLeft[r] - 6'h01);
        if (rkSel[r] && isAct) begin
          actCount[r] <= 3'(actCount[r] + 3'h1);                               // [R1]
        end
      end
    end

    always_ff @(posedge core_clk) begin
      if (rst) begin
        windowFull[r] <= 1'b0;
      end else begin
        windowFull[r] <= limitOn && (actCount[r] >= 3'(dct_pkg::ACT_LIMIT));
      end
    end
  end

  for (genvar k = 0; k < RB; k++) begin : g_bank
    dct_gap_timer #(.W(dct_pkg::GAP_W)) u_preAct (
      .core_clk(core_clk), .rst(rst),
      .start(rbSel[k] && reqCmd == 3'(dct_pkg::CMD_PRE)),
      .gap(gPreAct), .ready(rdyPreAct[k]));                                  // [R4]
    dct_gap_timer #(.W(dct_pkg::GAP_W)) u_actWr (
      .core_clk(core_clk), .rst(rst), .start(rbSel[k] && isAct),
      .gap(gActWr), .ready(rdyActWr[k]));                                    // [R7]
    dct_gap_timer #(.W(dct_pkg::GAP_W)) u_actRd (
      .core_clk(core_clk), .rst(rst), .start(rbSel[k] && isAct),
      .gap(gActRd), .ready(rdyActRd[k]));                                    // [R11]
  end

  dct_gap_timer #(.W(dct_pkg::GAP_W)) u_wrWrOther (
    .core_clk(core_clk), .rst(rst), .start(take && isWr),
    .gap(gWrWrOther), .ready(rdyWrWrOther));                                 // [R9]
  dct_gap_timer #(.W(dct_pkg::GAP_W)) u_rdWr (
    .core_clk(core_clk), .rst(rst), .start(take && isRd),
    .gap(gRdWr), .ready(rdyRdWr));                                           // [R10]
  dct_gap_timer #(.W(dct_pkg::GAP_W)) u_wrRdOther (
    .core_clk(core_clk), .rst(rst), .start(take && isWr),
    .gap(gWrRdOther), .ready(rdyWrRdOther));                                 // [R13]
  dct_gap_timer #(.W(dct_pkg::GAP_W)) u_rdRdOther (
    .core_clk(core_clk), .rst(rst), .start(take && isRd),
    .gap(gRdRdOther), .ready(rdyRdRdOther));                                 // [R15]

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic launchAct;
  logic launchRd;
  logic launchWr;
  assign launchAct = launchValid && launchCmd == 3'(dct_pkg::CMD_ACT);
  assign launchRd  = launchValid && launchCmd == 3'(dct_pkg::CMD_RD);
  assign launchWr  = launchValid && launchCmd == 3'(dct_pkg::CMD_WR);

  act_window_a: assert property ( // [R1]
    launchAct && $past(limitOn) |-> $past(actCount[reqRank]) < 3'h4)
    else $error("activate launched past the window limit");
  limit_off_a: assert property ( // [R2]
    reqValid && isAct && !launchValid && !limitOn && rdyActAct[reqRank]
    && rdyPreAct[reqRb] && rdyPreallAct[reqRank] && rdyRefAct[reqRank] |=> launchAct)
    else $error("activate held with the limit switched off");
  act_act_a: assert property ( // [R3]
    launchAct ##2 (launchAct && gActAct > 4'h2) |-> launchRank != $past(launchRank, 2))
    else $error("activates to one rank closer than the gap");
  pre_act_a: assert property ( // [R4]
    launchAct |-> $past(rdyPreAct[reqRb]))
    else $error("activate launched before the precharge gap");
  ref_act_a: assert property ( // [R6]
    launchValid && launchCmd == 3'(dct_pkg::CMD_REF) && gRefAct > 9'h004 |->
    ##2 !(launchAct && launchRank == $past(launchRank, 2))
    ##1 !(launchAct && launchRank == $past(launchRank, 3))
    ##1 !(launchAct && launchRank == $past(launchRank, 4)))
    else $error("activate launched inside the refresh gap");
  act_wr_a: assert property ( // [R7]
    launchWr |-> $past(rdyActWr[reqRb]) && $past(rdyRdWr))
    else $error("write launched before its activate or read gap");
  wr_rd_a: assert property ( // [R12]
    launchRd |-> $past(rdyWrRdSame[reqRank]) && $past(rdyRdRdSame[reqRank]))
    else $error("read launched inside a same-rank gap");
  zero_gap_a: assert property ( // [R16]
    launchAct && gActAct == 4'h0 |-> rdyActAct[launchRank])
    else $error("zero gap left a wait behind");
  no_double_a: assert property (launchValid |=> !launchValid)
    else $error("two launches back to back");

  act_launch_c: cover property (launchAct ##2 launchAct);
  window_full_c: cover property (windowFull != 4'h0);
  read_write_c: cover property (launchRd ##[2:20] launchWr);

endmodule : dct_spacing_tracker

`default_nettype wire

// *** verification/dct_dram_model.sv ***
// Purpose: Launch log standing in for the memory devices of the channel.
// Assumes: Every pulse of launchValid is one command on the memory bus.
// Notes:   The bench compares the logged count with what it issued.
`timescale 1ns/10ps
`default_nettype none

module dct_dram_model (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic launchValid,
  output var  int   launchCount
);
  // A lost or doubled pulse shows up as a count that differs from the bench's own.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      launchCount <= 0;
    end else if (launchValid) begin
      launchCount <= launchCount + 1;
    end
  end
endmodule : dct_dram_model
`default_nettype wire

// *** verification/dct_tb.sv ***
// Purpose: Self-checking bench for the command-spacing tracker.
// Assumes: Register and scheduler inputs change on the falling edge.
// Notes:   Idle time after each pair lets every gap timer run out.
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic                       core_clk  = 1'b0;
  logic                       rst       = 1'b1;
  logic [11:0]                cfgAddr   = 12'h000;
  logic                       cfgWrEn   = 1'b0;
  logic                       cfgRdEn   = 1'b0;
  logic [7:0]                 cfgWrData = 8'h00;
  logic                       reqValid  = 1'b0;
  logic [2:0]                 reqCmd    = 3'h0;
  logic [dct_pkg::RANK_W-1:0] reqRank   = 2'h0;
  logic [dct_pkg::BANK_W-1:0] reqBank   = 3'h0;
  logic [7:0]                 cfgRdData;
  logic                       launchValid;
  logic [2:0]                 launchCmd;
  logic [dct_pkg::RANK_W-1:0] launchRank;
  logic [dct_pkg::BANK_W-1:0] launchBank;
  logic [dct_pkg::RANKS-1:0]  windowFull;
  logic                       sawFull   = 1'b0;
  int                         launchCount;
  int                         fails = 0;
  int                         samples_checked = 0;
  int                         cyc = 0;
  int                         issued = 0;
  // Image of all nine bytes: read, write and activate timing, low byte first.
  logic [71:0]                image = 72'h11_1ac6_394b_000ace13;

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  always @(negedge core_clk) if (windowFull[0] === 1'b1) sawFull = 1'b1;

  dct_spacing_tracker dut (.core_clk(core_clk), .rst(rst), .cfgAddr(cfgAddr),
    .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
    .reqValid(reqValid), .reqCmd(reqCmd), .reqRank(reqRank), .reqBank(reqBank),
    .launchValid(launchValid), .launchCmd(launchCmd), .launchRank(launchRank),
    .launchBank(launchBank), .windowFull(windowFull));
  dct_dram_model dram (.core_clk(core_clk), .rst(rst), .launchValid(launchValid),
    .launchCount(launchCount));

  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic cfg_wr(input logic [11:0] a, input logic [7:0] d);
    cfgAddr = a;
    cfgWrData = d;
    cfgWrEn = 1'b1;
    @(negedge core_clk);
    cfgWrEn = 1'b0;
  endtask : cfg_wr

  task automatic cfg_rd(input logic [11:0] a, input logic [7:0] exp);
    cfgAddr = a;
    cfgRdEn = 1'b1;
    @(negedge core_clk);
    cfgRdEn = 1'b0;
    check("read byte", {24'h0, exp}, {24'h0, cfgRdData});
  endtask : cfg_rd

  // The request stays up until the launch is seen, as the scheduler would hold it.
  task automatic issue(input logic [2:0] c, input logic [1:0] r, input logic [2:0] b,
                       output int at);
    reqCmd = c;
    reqRank = r;
    reqBank = b;
    reqValid = 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(negedge core_clk);
      if (launchValid === 1'b1) begin
        at = cyc;
        issued++;
        check("launch", {24'h0, c, r, b}, {24'h0, launchCmd, launchRank, launchBank});
        return;
      end
    end
    fails++;
    $display("Error launch wait expected pulse seen none");
    stop_test();
  endtask : issue

  task automatic idle(input int n);
    reqValid = 1'b0;
    repeat (n) @(negedge core_clk);
  endtask : idle

  task automatic pair(input logic [2:0] c1, input logic [1:0] r1, input logic [2:0] b1,
                      input logic [2:0] c2, input logic [1:0] r2, input logic [2:0] b2,
                      input int exp);
    int t1;
    int t2;
    issue(c1, r1, b1, t1);
    issue(c2, r2, b2, t2);
    check("spacing", exp, t2 - t1);
    idle(40);
  endtask : pair

  // Five activates to rank 0; with the limit on the fifth waits out the window.
  task automatic burst(input logic on);
    int t0;
    int p;
    int t;
    issue(dct_pkg::CMD_ACT, 2'h0, 3'h0, t0);
    p = t0;
    for (int b = 1; b < 5; b++) begin
      issue(dct_pkg::CMD_ACT, 2'h0, 3'(b), t);
      if (on && b == 4) check("window end", 1, (t - t0 >= 40) && (t - t0 <= 41));
      else check("act spacing", 2, t - p);
      p = t;
    end
    idle(50);
  endtask : burst

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 9; i++) cfg_rd(dct_pkg::ACTIVATE_TIMING_OFS + 12'(i), 8'h00);
    cfg_wr(12'h655, 8'hff);
    cfg_rd(12'h655, 8'h0f);
    cfg_wr(12'h65a, 8'hff);
    cfg_rd(12'h65a, 8'h1f);
    cfg_wr(12'h65b, 8'hff);
    cfg_rd(12'h65b, 8'h00);
    for (int i = 0; i < 9; i++) cfg_wr(12'h652 + 12'(i), image[8*i +: 8]);
    for (int i = 0; i < 9; i++) cfg_rd(12'h652 + 12'(i), image[8*i +: 8]);
    pair(dct_pkg::CMD_ACT, 2'h0, 3'h0, dct_pkg::CMD_ACT, 2'h0, 3'h1, 5);
    pair(dct_pkg::CMD_ACT, 2'h0, 3'h0, dct_pkg::CMD_ACT, 2'h1, 3'h0, 2);
    pair(dct_pkg::CMD_PRE, 2'h1, 3'h2, dct_pkg::CMD_ACT, 2'h1, 3'h2, 6);
    pair(dct_pkg::CMD_PREALL, 2'h2, 3'h0, dct_pkg::CMD_ACT, 2'h2, 3'h5, 7);
    pair(dct_pkg::CMD_REF, 2'h3, 3'h0, dct_pkg::CMD_ACT, 2'h3, 3'h0, 19);
    pair(dct_pkg::CMD_ACT, 2'h0, 3'h3, dct_pkg::CMD_WR, 2'h0, 3'h3, 3);
    pair(dct_pkg::CMD_WR, 2'h2, 3'h0, dct_pkg::CMD_WR, 2'h2, 3'h1, 9);
    pair(dct_pkg::CMD_WR, 2'h2, 3'h0, dct_pkg::CMD_WR, 2'h3, 3'h0, 4);
    pair(dct_pkg::CMD_RD, 2'h0, 3'h0, dct_pkg::CMD_WR, 2'h1, 3'h0, 11);
    pair(dct_pkg::CMD_ACT, 2'h1, 3'h4, dct_pkg::CMD_RD, 2'h1, 3'h4, 8);
    pair(dct_pkg::CMD_WR, 2'h1, 3'h1, dct_pkg::CMD_RD, 2'h1, 3'h2, 17);
    pair(dct_pkg::CMD_WR, 2'h1, 3'h1, dct_pkg::CMD_RD, 2'h2, 3'h2, 10);
    pair(dct_pkg::CMD_RD, 2'h3, 3'h0, dct_pkg::CMD_RD, 2'h3, 3'h1, 12);
    pair(dct_pkg::CMD_RD, 2'h3, 3'h0, dct_pkg::CMD_RD, 2'h0, 3'h0, 6);
    pair(dct_pkg::CMD_PRE, 2'h0, 3'h0, dct_pkg::CMD_PRE, 2'h0, 3'h1, 2);
    // Window of 40 with a zero activate gap, limit first off, then on.
    cfg_wr(12'h655, 8'h0a);
    cfg_wr(12'h654, 8'h00);
    burst(1'b0);
    check("window flag off", 0, sawFull);
    cfg_wr(12'h654, 8'h20);
    burst(1'b1);
    check("window flag on", 1, sawFull);
    check("launch count", issued, launchCount);
    stop_test();
  end
endmodule : tb
`default_nettype wire
